/* verilog/thermal_threshold_monitor.sv */
// thermal threshold monitor: special registers, compare sequencer, interrupt
//
// What this block does
// - hard reset clears all three registers; monitor idles until enabled
// - registers reached only by supervisor special-register reads and writes
// - bit 0 of each limit register is read-only crossing flag
// - bit 1 is read-only valid flag, set once a result is held
// - bits 2 to 8 hold threshold 0 to 127 degrees, compared to sensor
// - bit 29 picks direction: above threshold when zero, below when one
// - bit 30 enables the interrupt for that register's crossing
// - with interrupt disabled, valid register still updates crossing flag
// - interrupt is also gated by the processor's global interrupt enable
// - bit 31 marks register valid; sensor runs only with control bit 31 set
// - control bits 18 to 30 give cycles before a result is sampled
// - control bit 31 enables comparisons when a limit register is valid
// - while enabled, compare periodically and interrupt on enabled crossings
// - start with register a if eligible, else b; alternate after each interval while both are
// - interrupt held until recognised; then that register freezes until written
// - limit write clears its valid flag; control write clears both; restart
`timescale 1ns/10ps
`include "thermal_monitor_defs.svh"
module thermal_threshold_monitor
  import thermal_monitor_pkg::*;
#(
  parameter int INTERVAL_WIDTH  = 13,
  parameter int THRESHOLD_WIDTH = 7
)
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // special-register port
  input  wire logic                       supervisor,
  input  wire logic [1:0]                 sprSel,
  input  wire logic                       sprWrite,
  input  wire logic                       sprRead,
  input  wire logic [31:0]                sprWdata,
  output logic      [31:0]                sprRdata,
  // analog front end
  input  wire logic                       compAbove,
  output logic      [THRESHOLD_WIDTH-1:0] dacCode,
  output logic                            sensorActive,
  // interrupt unit
  input  wire logic                       globalIrqGate,
  input  wire logic                       irqAck,
  output logic                            thermIrq
);

  // ==========================================================================
  // register port decode
  // ==========================================================================
  logic       wrLimit [2];
  logic       wrControl;
  logic       rdHit;
  limit_s     wrLimitVal;
  control_s   wrControlVal;

  // user-mode writes are ignored; user-mode reads return zero
  assign wrLimit[0] = sprWrite && supervisor && (sprSel == `TM_SEL_LIMIT_A);
  assign wrLimit[1] = sprWrite && supervisor && (sprSel == `TM_SEL_LIMIT_B);
  assign wrControl  = sprWrite && supervisor && (sprSel == `TM_SEL_CONTROL);
  assign rdHit      = sprRead && supervisor;

  // status and reserved bits of a write are dropped
  always_comb
  begin
    wrLimitVal               = `TM_LIMIT_RESET;
    wrLimitVal.valid         = sprWdata[`TM_LIMVALID_BIT];
    wrLimitVal.irqEnable     = sprWdata[`TM_IRQEN_BIT];
    wrLimitVal.direction     = sprWdata[`TM_DIR_BIT];
    wrLimitVal.threshold     = sprWdata[`TM_THRESH_MSB:`TM_THRESH_LSB];
    wrControlVal             = `TM_CONTROL_RESET;
    wrControlVal.enable      = sprWdata[`TM_ENABLE_BIT];
    wrControlVal.interval    = sprWdata[`TM_INTERVAL_MSB:`TM_INTERVAL_LSB];
  end

  // ==========================================================================
  // sample control register
  // ==========================================================================
  control_s control;
  control_s next_control;

  always_comb
  begin
    next_control = control;
    if (wrControl)
    begin
      next_control = wrControlVal;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      control <= `TM_CONTROL_RESET;
    end
    else
    begin
      control <= next_control;
    end
  end

  // ==========================================================================
  // sequencer state
  // ==========================================================================
  seq_e   state;
  seq_e   next_state;
  logic   curSel;
  logic   next_curSel;
  logic   tick;
  logic   restart;
  logic   crossing;
  logic   eligible   [2];
  logic   sampleHit  [2];
  limit_s limit      [2];
  logic   halted     [2];
  logic   pending    [2];

  // the comparator result, read in the sense of the active register
  assign crossing = limit[curSel].direction ? !compAbove : compAbove;

  // any register write restarts the comparison from the start of an interval
  assign restart  = wrLimit[0] || wrLimit[1] || wrControl;

  // ==========================================================================
  // threshold registers, one per channel
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_limit
      limit_s next_limit;
      logic   next_halted;
      logic   next_pending;

      // a frozen register takes no part until written again
      assign eligible[gi]  = control.enable && limit[gi].valid && !halted[gi];
      assign sampleHit[gi] = tick && (curSel == 1'(gi)) && eligible[gi];

      always_comb
      begin
        next_limit   = limit[gi];
        next_halted  = halted[gi];
        next_pending = pending[gi];
        // recognition freezes the flags of the interrupting register
        if (irqAck && pending[gi])
        begin
          next_halted  = 1'b1;
          next_pending = 1'b0;
        end
        if (wrLimit[gi])
        begin
          next_limit.valid         = wrLimitVal.valid;
          next_limit.irqEnable     = wrLimitVal.irqEnable;
          next_limit.direction     = wrLimitVal.direction;
          next_limit.threshold     = wrLimitVal.threshold;
          next_limit.crossingValid = 1'b0;
          next_halted              = 1'b0;
          next_pending             = 1'b0;
        end
        if (wrControl)
        begin
          next_limit.crossingValid = 1'b0;
        end
        // a write blocks the tick, so no sample lands in the clearing cycle
        if (sampleHit[gi])
        begin
          next_limit.crossingFlag  = crossing;
          next_limit.crossingValid = 1'b1;
          if (crossing && limit[gi].irqEnable)
          begin
            next_pending = 1'b1;
          end
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          limit[gi]   <= `TM_LIMIT_RESET;
          halted[gi]  <= 1'b0;
          pending[gi] <= 1'b0;
        end
        else
        begin
          limit[gi]   <= next_limit;
          halted[gi]  <= next_halted;
          pending[gi] <= next_pending;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // compare sequencer
  // ==========================================================================
  always_comb
  begin
    next_state  = state;
    next_curSel = curSel;
    unique case (state)
      ST_IDLE:
      begin
        // counter cleared, flags untouched while nothing is eligible
        next_curSel = !eligible[0];
        if (eligible[0] || eligible[1])
        begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE:
      begin
        if (!(eligible[0] || eligible[1]))
        begin
          next_state = ST_IDLE;
        end
        else if (restart)
        begin
          next_curSel = !eligible[0];
        end
        else if (tick || !eligible[curSel])
        begin
          // alternate when the other register can take a turn
          if (eligible[!curSel])
          begin
            next_curSel = !curSel;
          end
        end
      end
      default:
      begin
        next_state  = ST_IDLE;
        next_curSel = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state  <= ST_IDLE;
      curSel <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      curSel <= next_curSel;
    end
  end

  sample_timer #(
    .WIDTH    (INTERVAL_WIDTH)
  ) u_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .run      (state == ST_SAMPLE),
    .restart  (restart),
    .interval (control.interval),
    .tick     (tick)
  );

  // ==========================================================================
  // front end drive and read-back
  // ==========================================================================
  logic [THRESHOLD_WIDTH-1:0] next_dacCode;
  logic [31:0]                next_sprRdata;

  always_comb
  begin
    next_dacCode  = limit[next_curSel].threshold;
    next_sprRdata = sprRdata;
    if (rdHit)
    begin
      unique case (sprSel)
        `TM_SEL_LIMIT_A: next_sprRdata = limit[0];
        `TM_SEL_LIMIT_B: next_sprRdata = limit[1];
        `TM_SEL_CONTROL: next_sprRdata = control;
        default:         next_sprRdata = 32'h0000_0000;
      endcase
    end
    else if (sprRead)
    begin
      next_sprRdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dacCode  <= '0;
      sprRdata <= 32'h0000_0000;
    end
    else
    begin
      dacCode  <= next_dacCode;
      sprRdata <= next_sprRdata;
    end
  end

  // low-power front end unless a comparison is running
  assign sensorActive = (state == ST_SAMPLE);

  // held until recognised, masked by the global interrupt gate
  assign thermIrq = globalIrqGate && (pending[0] || pending[1]);

endmodule

/* pkg/thermal_monitor_defs.svh */
// thermal monitor constants: register selects, field positions, reset values, timing
`ifndef THERMAL_MONITOR_DEFS_SVH
`define THERMAL_MONITOR_DEFS_SVH

// special-register select codes on the register port
`define TM_SEL_LIMIT_A        2'h0
`define TM_SEL_LIMIT_B        2'h1
`define TM_SEL_CONTROL        2'h2

// threshold register fields
`define TM_FLAG_BIT           0
`define TM_VALID_BIT          1
`define TM_THRESH_LSB         2
`define TM_THRESH_MSB         8
`define TM_DIR_BIT            29
`define TM_IRQEN_BIT          30
`define TM_LIMVALID_BIT       31

// sample control register fields
`define TM_INTERVAL_LSB       18
`define TM_INTERVAL_MSB       30
`define TM_ENABLE_BIT         31

// reset values
`define TM_LIMIT_RESET        32'h0000_0000
`define TM_CONTROL_RESET      32'h0000_0000

// recommended settling interval, a software setting
`define TM_CLK_MHZ            20
`define TM_SAMPLE_TIME_US     20
`define TM_SAMPLE_CYCLES      (`TM_SAMPLE_TIME_US * `TM_CLK_MHZ)

`endif

/* pkg/thermal_monitor_pkg.sv */
// thermal monitor types: register layouts and sequencer states
package thermal_monitor_pkg;

  typedef struct packed {
    logic        valid;
    logic        irqEnable;
    logic        direction;
    logic [19:0] reserved;
    logic [6:0]  threshold;
    logic        crossingValid;
    logic        crossingFlag;
  } limit_s;

  typedef struct packed {
    logic        enable;
    logic [12:0] interval;
    logic [17:0] reserved;
  } control_s;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_SAMPLE = 2'b10
  } seq_e;

endpackage

/* verilog/sample_timer.sv */
// sample interval timer: one-cycle tick after the programmed number of cycles
`timescale 1ns/10ps
module sample_timer
  import thermal_monitor_pkg::*;
#(
  parameter int WIDTH = 13
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // control
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] interval,
  // enable pulse
  output logic                  tick
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] target;

  // an interval of zero behaves as one cycle
  assign target = (interval == '0) ? WIDTH'(1) : interval;
  assign tick   = run && !restart && ((count + WIDTH'(1)) >= target);

  always_comb
  begin
    next_count = count + WIDTH'(1);
    if (!run || restart || tick)
    begin
      next_count = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end

endmodule

/* bench/tm_checker_props.sv */
// port assertions for the thermal threshold monitor
`timescale 1ns/10ps
module tm_checker
  import thermal_monitor_pkg::*;
#(
  parameter int THRESHOLD_WIDTH = 7
)
(
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       rst,
  // register port
  input wire logic                       supervisor,
  input wire logic [1:0]                 sprSel,
  input wire logic                       sprWrite,
  input wire logic                       sprRead,
  input wire logic [31:0]                sprWdata,
  input wire logic [31:0]                sprRdata,
  // front end
  input wire logic                       compAbove,
  input wire logic [THRESHOLD_WIDTH-1:0] dacCode,
  input wire logic                       sensorActive,
  // interrupt unit
  input wire logic                       globalIrqGate,
  input wire logic                       irqAck,
  input wire logic                       thermIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================
  // sequences
  sequence s_unpriv_read;
    sprRead && !supervisor;
  endsequence
  sequence s_unmapped_read;
    sprRead && sprSel == 2'h3;
  endsequence
  sequence s_disable_write;
    sprWrite && supervisor && sprSel == 2'h2 && !sprWdata[31];
  endsequence
  // ==========================================
  // properties
  AST_RESET_CLEAR: assert property ($past(rst) |-> sprRdata == 32'h0000_0000
    && !thermIrq && !sensorActive) else $error("outputs not clear after reset");
  AST_UNPRIV_READ: assert property (s_unpriv_read |=> sprRdata == 32'h0000_0000)
    else $error("unprivileged read returned data");
  AST_UNMAPPED: assert property (s_unmapped_read |=> sprRdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  AST_RDATA_HOLD: assert property (!rst && !sprRead |=> $stable(sprRdata))
    else $error("read data moved without a read");
  AST_RSVD_ZERO: assert property (sprRead && supervisor && !sprSel[1]
    |=> sprRdata[28:9] == 20'h0_0000) else $error("reserved limit bits not zero");
  AST_IDLE_OFF: assert property (s_disable_write |-> ##[1:2] !sensorActive)
    else $error("sensor active after disable");
  AST_IRQ_GATE: assert property (thermIrq |-> globalIrqGate)
    else $error("interrupt not masked by global gate");
  AST_IRQ_CAUSE: assert property ($rose(thermIrq) |-> $rose(globalIrqGate)
    || $past(sensorActive)) else $error("interrupt without a sample");
  AST_IRQ_HOLD: assert property (thermIrq && !irqAck && !sprWrite
    |=> thermIrq || !globalIrqGate) else $error("interrupt dropped before ack");
endmodule
bind thermal_threshold_monitor tm_checker #(.THRESHOLD_WIDTH(THRESHOLD_WIDTH)) u_checker (.*);

/* bench/core_model.sv */
// interrupt unit model: recognises the thermal interrupt after a delay
`timescale 1ns/10ps
module core_model
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // interrupt unit
  input  wire logic ackOn,
  input  wire logic thermIrq,
  output logic      irqAck
);
  int waitCount;
  // one-cycle recognition pulse, only while the interrupt stands
  always @(posedge clk_sys)
  begin
    if (rst || !ackOn || !thermIrq || irqAck)
    begin
      waitCount <= 0;
      irqAck    <= 1'b0;
    end
    else if (waitCount == 3)
      irqAck <= 1'b1;
    else
      waitCount <= waitCount + 1;
  end
endmodule

/* bench/tb.sv */
// self-checking testbench for the thermal threshold monitor
`timescale 1ns/10ps
`include "thermal_monitor_defs.svh"
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb
  import thermal_monitor_pkg::*;
;
  localparam int N = 6;
  logic        clk_sys, rst, supervisor, sprWrite, sprRead, globalIrqGate, ackOn;
  logic        irqAck, thermIrq, sensorActive;
  logic [1:0]  sprSel;
  logic [31:0] sprWdata, sprRdata, rd;
  logic [6:0]  dacCode;
  logic [7:0]  tempC;
  int          bad_count, comparisons;
  wire logic   compAbove = tempC > {1'b0, dacCode};

  thermal_threshold_monitor u_dut (.clk_sys(clk_sys), .rst(rst), .supervisor(supervisor),
    .sprSel(sprSel), .sprWrite(sprWrite), .sprRead(sprRead), .sprWdata(sprWdata),
    .sprRdata(sprRdata), .compAbove(compAbove), .dacCode(dacCode),
    .sensorActive(sensorActive), .globalIrqGate(globalIrqGate), .irqAck(irqAck),
    .thermIrq(thermIrq));
  core_model u_core (.clk_sys(clk_sys), .rst(rst), .ackOn(ackOn), .thermIrq(thermIrq),
    .irqAck(irqAck));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] lim(logic v, logic ie, logic dir, logic [6:0] thr);
    return {v, ie, dir, 20'h0_0000, thr, 2'b00};
  endfunction
  task automatic special_purpose_reg(input logic wr, input logic [1:0] sel, input logic [31:0] d,
                     input logic priv = 1'b1);
    @(posedge clk_sys);
    #1 {sprWrite, sprRead, sprSel, sprWdata, supervisor} = {wr, !wr, sel, d, priv};
    @(posedge clk_sys);
    #1 {sprWrite, sprRead} = 2'b00;
    rd = sprRdata;
  endtask
  task automatic test_done();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_access();
    for (int s = 0; s < 4; s++)
    begin
      special_purpose_reg(1'b0, s[1:0], 32'h0);
      `CHECK(rd, 32'h0000_0000)
    end
    special_purpose_reg(1'b1, 2'h0, 32'hFFFF_FFFF);
    special_purpose_reg(1'b1, 2'h0, 32'h0000_0000, 1'b0);
    special_purpose_reg(1'b0, 2'h0, 32'h0);
    `CHECK(rd, 32'hE000_01FC)
    special_purpose_reg(1'b0, 2'h0, 32'h0, 1'b0);
    `CHECK(rd, 32'h0000_0000)
    special_purpose_reg(1'b1, 2'h2, 32'h7FFF_FFFF);
    special_purpose_reg(1'b0, 2'h2, 32'h0);
    `CHECK(rd, 32'h7FFC_0000)
    `CHECK(sensorActive, 1'b0)
  endtask
  task automatic t_sample();
    logic       dirs[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] temps[4] = '{8'h3C, 8'h32, 8'h28, 8'h7F};
    logic [6:0] thrs[4] = '{7'h32, 7'h32, 7'h32, 7'h7F};
    logic [31:0] expVal;
    special_purpose_reg(1'b1, 2'h2, {1'b1, 13'(N), 18'h0_0000});
    for (int i = 0; i < 4; i++)
    begin
      tempC = temps[i];
      special_purpose_reg(1'b1, 2'h0, lim(1'b1, 1'b0, dirs[i], thrs[i]));
      special_purpose_reg(1'b0, 2'h0, 32'h0);
      `CHECK(rd[1], 1'b0)
      `CHECK(sensorActive, 1'b1)
      repeat (N - 4) @(posedge clk_sys);
      special_purpose_reg(1'b0, 2'h0, 32'h0);
      `CHECK(rd[1], 1'b0)
      special_purpose_reg(1'b0, 2'h0, 32'h0);
      expVal = lim(1'b1, 1'b0, dirs[i], thrs[i]) | {1'b1, dirs[i] ^ (temps[i] > thrs[i])};
      `CHECK(rd, expVal)
      `CHECK(thermIrq, 1'b0)
      `CHECK(dacCode, thrs[i])
    end
  endtask
  task automatic t_irq();
    tempC = 8'h3C;
    special_purpose_reg(1'b1, 2'h0, lim(1'b1, 1'b1, 1'b0, 7'h32));
    repeat (N + 2) @(posedge clk_sys);
    #1 `CHECK(thermIrq, 1'b0)
    globalIrqGate = 1'b1;
    @(posedge clk_sys);
    #1 `CHECK(thermIrq, 1'b1)
    ackOn = 1'b1;
    for (int k = 0; k < 20 && thermIrq !== 1'b0; k++)
    begin
      @(posedge clk_sys);
      #1;
    end
    `CHECK(thermIrq, 1'b0)
    tempC = 8'h28;
    repeat (3 * N) @(posedge clk_sys);
    special_purpose_reg(1'b0, 2'h0, 32'h0);
    `CHECK(rd[1:0], 2'b11)
    special_purpose_reg(1'b1, 2'h0, lim(1'b1, 1'b0, 1'b0, 7'h32));
    repeat (N) @(posedge clk_sys);
    special_purpose_reg(1'b0, 2'h0, 32'h0);
    `CHECK(rd[1:0], 2'b10)
  endtask
  task automatic t_dual();
    tempC = 8'h3C;
    special_purpose_reg(1'b1, 2'h0, lim(1'b1, 1'b0, 1'b0, 7'h64));
    special_purpose_reg(1'b1, 2'h1, lim(1'b1, 1'b0, 1'b0, 7'h14));
    special_purpose_reg(1'b1, 2'h2, {1'b1, 13'(N), 18'h0_0000});
    `CHECK(dacCode, 7'h64)
    repeat (N - 1) @(posedge clk_sys);
    special_purpose_reg(1'b0, 2'h0, 32'h0);
    `CHECK(rd[1:0], 2'b10)
    special_purpose_reg(1'b0, 2'h1, 32'h0);
    `CHECK(rd[1], 1'b0)
    `CHECK(dacCode, 7'h14)
    repeat (N - 4) @(posedge clk_sys);
    special_purpose_reg(1'b0, 2'h1, 32'h0);
    `CHECK(rd[1:0], 2'b11)
    special_purpose_reg(1'b1, 2'h2, {1'b0, 13'(N), 18'h0_0000});
    repeat (2 * N) @(posedge clk_sys);
    `CHECK(sensorActive, 1'b0)
    special_purpose_reg(1'b0, 2'h0, 32'h0);
    `CHECK(rd[1], 1'b0)
    special_purpose_reg(1'b0, 2'h1, 32'h0);
    `CHECK(rd[1], 1'b0)
  endtask
  task automatic t_reset();
    // recommended settling interval, then a hard reset in mid-run
    special_purpose_reg(1'b1, 2'h2, {1'b1, 13'(`TM_SAMPLE_CYCLES), 18'h0_0000});
    repeat (`TM_SAMPLE_CYCLES - 1) @(posedge clk_sys);
    special_purpose_reg(1'b0, 2'h0, 32'h0);
    `CHECK(rd[1], 1'b0)
    special_purpose_reg(1'b0, 2'h0, 32'h0);
    `CHECK(rd[1:0], 2'b10)
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      special_purpose_reg(1'b0, s[1:0], 32'h0);
      `CHECK(rd, 32'h0000_0000)
    end
    `CHECK(sensorActive, 1'b0)
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    {rst, supervisor, sprWrite, sprRead, globalIrqGate, ackOn} = 6'b110000;
    {sprSel, sprWdata, tempC} = '0;
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_access();
    t_sample();
    t_irq();
    t_dual();
    t_reset();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    test_done();
  end
endmodule
